//--- verilog/tpbs_top.sv
/*
 * Timer count-clock prescaler and data-move bus stretcher with a classic
 * Wishbone register slave. One control byte holds three timer clock selects
 * and a three-bit stretch value; a status word shows the move sequencer.
 * Timer ticks are single-cycle enables at oscillator/12 or oscillator/4.
 * A data move holds its read or write strobe for two machine cycles plus
 * the stretch value, or for two machine cycles when it targets on-chip RAM.
 * Assumes a single 125 MHz clock, an asynchronous active-low reset and a core
 * that issues one data-move request at a time and waits for done. The core's
 * request, target and direction come from logic on the same clock, so they
 * are read without synchronisers.
 */
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tpbs_consts.svh"

module tpbs_top
    import tpbs_pkg::*;
#(
    parameter int N_TIMERS = 3
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_resetn,
    // Wishbone slave
    input  wire logic                 i_wb_cyc,
    input  wire logic                 i_wb_stb,
    input  wire logic                 i_wb_we,
    input  wire logic [3:0]           i_wb_adr,
    input  wire logic [3:0]           i_wb_sel,
    input  wire logic [31:0]          i_wb_dat,
    output logic      [31:0]          o_wb_dat,
    output logic                      o_wb_ack,
    // Data-move request from the core
    input  wire logic                 i_mv_req,
    input  wire logic                 i_mv_internal,
    input  wire logic                 i_mv_write,
    output logic                      o_mv_rd_strobe,
    output logic                      o_mv_wr_strobe,
    output logic                      o_mv_done,
    // Timer count ticks
    output logic [N_TIMERS-1:0]       o_timer_tick
);

    // ==========================================================
    // Reset release
    logic [1:0] rst_sync_q;
    logic       rst_n;

    // Two stages so the release is clean against i_clk;
    // assertion stays asynchronous, release lands two edges later
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    // Internal reset for every register below
    assign rst_n = rst_sync_q[1];

    // ==========================================================
    // Register slave
    logic [7:0]  ctrl_q,  ctrl_d;
    logic        ack_q,   ack_d;
    logic [31:0] rdat_q,  rdat_d;
    logic        bus_req;
    tpbs_mv_e    mv_q,    mv_d;

    // A request is taken once; the held strobe is ignored while ack stands,
    // so a master that keeps stb up through the ack edge does not write twice
    assign bus_req = i_wb_cyc && i_wb_stb && !ack_q;

    // Decode, one-cycle ack; unmapped reads return zero, writes dropped
    // Byte lane 0 only; the other lanes carry nothing
    always_comb begin
        ctrl_d = ctrl_q;
        ack_d  = bus_req;
        rdat_d = rdat_q;
        if (bus_req) begin
            rdat_d = 32'h0000_0000;
            if (i_wb_adr == `TPBS_ADDR_CTRL) begin
                rdat_d = {24'h00_0000, ctrl_q};
                if (i_wb_we && i_wb_sel[0]) begin
                    ctrl_d = i_wb_dat[7:0] & `TPBS_CTRL_MASK; // Bits 7:6 not kept
                end
            end else if (i_wb_adr == `TPBS_ADDR_STATUS) begin
                // Bit 1 busy, bit 0 done; read-only, writes fall through
                rdat_d = {30'h0000_0000, mv_q == TPBS_BUSY, o_mv_done};
            end
        end
    end

    // Registered answer: ack stands for exactly one cycle; read data holds until the next request
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `TPBS_CTRL_RESET;
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    // ==========================================================
    // Machine-cycle base
    logic [3:0] mc_cnt_q, mc_cnt_d;
    logic       mc_tick;

    // One machine cycle is a fixed number of oscillator clocks. The base runs
    // free, so a move that starts mid-cycle loses up to three clocks of its
    // first machine cycle; the strobe is at most three clocks short of nominal
    always_comb begin
        mc_tick  = (mc_cnt_q == `TPBS_MC_CLKS - 4'h1);
        mc_cnt_d = mc_tick ? 4'h0 : mc_cnt_q + 4'h1;
    end

    // Counter state only
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mc_cnt_q <= 4'h0;
        end else begin
            mc_cnt_q <= mc_cnt_d;
        end
    end

    // ==========================================================
    // Per-timer prescalers
    // One free-running counter per timer; ticks are enables, not clocks
    genvar g;
    generate
        for (g = 0; g < N_TIMERS; g++) begin : g_tmr
            logic [3:0] pre_q, pre_d;
            logic [3:0] div;
            logic       tick;

            // Select bits sit side by side from timer 0 upward. The compare is
            // greater-or-equal so a switch from /12 to /4 with the count past
            // three ticks at once instead of wrapping through sixteen clocks
            always_comb begin
                div  = ctrl_q[`TPBS_F_T0_SEL + g] ? `TPBS_DIV_FAST : `TPBS_DIV_SLOW;
                tick = (pre_q >= div - 4'h1);
                pre_d = tick ? 4'h0 : pre_q + 4'h1;
            end

            // Prescaler count
            always_ff @(posedge i_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pre_q <= 4'h0;
                end else begin
                    pre_q <= pre_d;
                end
            end
            assign o_timer_tick[g] = tick;
        end
    endgenerate

    // ==========================================================
    // Data-move sequencer
    // Idle, busy for the counted machine cycles, then one done cycle
    logic [3:0] mv_left_q, mv_left_d;
    logic       mv_wr_q,   mv_wr_d;
    logic [3:0] mv_len;

    // Length fixed at request; a field change mid-move does not disturb it
    // The stretch value and the target are read once, at the request edge
    always_comb begin
        mv_len    = i_mv_internal ? `TPBS_BASE_MC
                                  : `TPBS_BASE_MC + {1'b0, ctrl_q[2:0]};
        mv_d      = mv_q;
        mv_left_d = mv_left_q;
        mv_wr_d   = mv_wr_q;
        unique case (mv_q)
            TPBS_IDLE: begin
                if (i_mv_req) begin
                    mv_d      = TPBS_BUSY;
                    mv_left_d = mv_len;
                    mv_wr_d   = i_mv_write;
                end
            end
            TPBS_BUSY: begin
                // Count down whole machine cycles; requests are ignored here
                if (mc_tick) begin
                    mv_left_d = mv_left_q - 4'h1;
                    if (mv_left_q == 4'h1) begin
                        mv_d = TPBS_DONE;
                    end
                end
            end
            TPBS_DONE: begin
                // One-cycle done; a request held through it is taken only
                // once the sequencer is idle again
                mv_d = TPBS_IDLE;
            end
            default: begin
                // Unused code recovers to idle
                mv_d = TPBS_IDLE;
            end
        endcase
    end

    // Sequencer state only
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mv_q      <= TPBS_IDLE;
            mv_left_q <= 4'h0;
            mv_wr_q   <= 1'b0;
        end else begin
            mv_q      <= mv_d;
            mv_left_q <= mv_left_d;
            mv_wr_q   <= mv_wr_d;
        end
    end

    // Strobe covers the whole stretched interval; slow parts see it
    // from the first busy cycle to the last, and done follows the fall
    // with no gap, so the core may issue the next move right after it
    assign o_mv_rd_strobe = (mv_q == TPBS_BUSY) && !mv_wr_q;
    assign o_mv_wr_strobe = (mv_q == TPBS_BUSY) && mv_wr_q;
    assign o_mv_done      = (mv_q == TPBS_DONE);

endmodule

//--- common/tpbs_consts.svh
/*
 * Constants for the timer prescale and bus stretch block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef TPBS_CONSTS_SVH
`define TPBS_CONSTS_SVH

// ==========================================================
// Register map (byte addresses)
`define TPBS_ADDR_CTRL      4'h0
`define TPBS_ADDR_STATUS    4'h4
`define TPBS_ADDR_W         4

// ==========================================================
// Control register fields
`define TPBS_F_STRETCH_LO   0
`define TPBS_F_T0_SEL       3
`define TPBS_F_T1_SEL       4
`define TPBS_F_T2_SEL       5
`define TPBS_CTRL_MASK      8'h3F
`define TPBS_CTRL_RESET     8'h01

// ==========================================================
// Timing counts in oscillator clocks; the base move length is in machine cycles
`define TPBS_DIV_SLOW       4'hC
`define TPBS_DIV_FAST       4'h4
`define TPBS_MC_CLKS        4'h4
`define TPBS_BASE_MC        4'h2
`endif

//--- common/tpbs_pkg.sv
/*
 * Types for the timer prescale and bus stretch block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tpbs_pkg;
    typedef enum logic [1:0] {
        TPBS_IDLE = 2'b00,
        TPBS_BUSY = 2'b01,
        TPBS_DONE = 2'b10
    } tpbs_mv_e;
endpackage

//--- sim/tpbs_ext_mem.sv
/* Stand-in for slow external memory on the move strobes.
   Assumes one move at a time. */
`timescale 1ns/1ps
module tpbs_ext_mem (
    // Clock and strobes
    input  wire logic i_clk,
    input  wire logic i_rd_strobe,
    input  wire logic i_wr_strobe,
    // Clocks the last strobe lasted, and whether it was a write
    output int        o_last_len,
    output logic      o_last_wr
);
    int   run_q = 0;
    logic wr_q  = 1'b0;
    // Slow parts only need a long enough strobe
    always_ff @(posedge i_clk) begin
        if (i_rd_strobe | i_wr_strobe) begin
            run_q <= run_q + 1;
            wr_q  <= i_wr_strobe;
        end else if (run_q != 0) begin
            o_last_len <= run_q;
            o_last_wr  <= wr_q;
            run_q <= 0;
        end
    end
endmodule

//--- sim/tpbs_top_checker.sv
/* Port checker for tpbs_top.
   Assumes it is bound to every instance. */
`timescale 1ns/1ps
module tpbs_checker #(
    parameter int N_TIMERS = 3
) (
    // ====
    // Watched ports
    input wire logic       i_clk,
    input wire logic       i_resetn,
    input wire logic       i_mv_internal,
    input wire logic       o_wb_ack,
    input wire logic       o_mv_rd_strobe,
    input wire logic       o_mv_wr_strobe,
    input wire logic       o_mv_done,
    input wire logic [N_TIMERS-1:0] o_timer_tick
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    wire logic busy = o_mv_rd_strobe | o_mv_wr_strobe;
    // Shortest move is two machine cycles
    sequence s_min_hold;
        busy [*5];
    endsequence
    a_move_span: assert property ($rose(busy) |-> s_min_hold ##[1:32] o_mv_done)
        else $error("move length out of range");
    a_ram_span: assert property ($rose(busy) && i_mv_internal |-> s_min_hold ##[1:4] o_mv_done)
        else $error("on-chip move not two machine cycles");
    a_tick_gap: assert property (o_timer_tick[0] |=> !o_timer_tick[0] [*3])
        else $error("timer ticks too close");
    a_one_strobe: assert property (!(o_mv_rd_strobe && o_mv_wr_strobe))
        else $error("both strobes high");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
endmodule
bind tpbs_top tpbs_checker #(.N_TIMERS(N_TIMERS)) u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_mv_internal(i_mv_internal),
    .o_wb_ack(o_wb_ack), .o_mv_rd_strobe(o_mv_rd_strobe), .o_mv_wr_strobe(o_mv_wr_strobe),
    .o_mv_done(o_mv_done), .o_timer_tick(o_timer_tick));

//--- sim/tb_tpbs_top.sv
/* Self-checking bench for tpbs_top.
   Assumes the checker is bound and the memory model watches the strobes. */
`timescale 1ns/1ps
`include "tpbs_consts.svh"
module tb_tpbs_top;
    // ====
    // Stimulus and observation
    logic        i_clk = 0, i_resetn = 0, cyc = 0, stb = 0, we = 0, req = 0, intl = 0, wr = 0;
    logic [3:0]  adr = '0, bsel = '0;
    logic [7:0]  m_ctrl = `TPBS_CTRL_RESET;
    logic [31:0] wdat = '0, rdat, o_wb_dat;
    logic        ack, rds, wrs, done, last_wr;
    logic [2:0]  tick;
    wire  [4:0]  flags = {done, ack, tick};
    int          fail_count = 0, tests_run = 0, last_len;
    tpbs_top u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(bsel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(ack),
        .i_mv_req(req), .i_mv_internal(intl), .i_mv_write(wr), .o_mv_rd_strobe(rds),
        .o_mv_wr_strobe(wrs), .o_mv_done(done), .o_timer_tick(tick));
    tpbs_ext_mem u_mem (.i_clk(i_clk), .i_rd_strobe(rds), .i_wr_strobe(wrs), .o_last_len(last_len),
        .o_last_wr(last_wr));
    initial forever #4 i_clk = ~i_clk;
    // ====
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Wait for a flag (0..2 ticks, 3 ack, 4 done), counting edges; only the watchdog ends it
    task automatic await(input int k, output int n);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (flags[k] !== 1'b1);
    endtask
    // Classic cycle held until ack; the register model follows the rules
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        {cyc, stb, we, adr, wdat, bsel} <= {2'b11, w, a, d, s};
        await(3, n);
        rdat = o_wb_dat;
        if (w && s[0] && a == `TPBS_ADDR_CTRL) m_ctrl = d[7:0] & `TPBS_CTRL_MASK;
        {cyc, stb} <= 2'b00;
        @(posedge i_clk);
    endtask
    // One move; length and strobe kind checked against the model's machine cycles
    task automatic move(input logic i, input logic w);
        int n, mc;
        mc = i ? `TPBS_BASE_MC : `TPBS_BASE_MC + m_ctrl[2:0];
        {req, intl, wr} <= {1'b1, i, w};
        @(posedge i_clk);
        req <= 0;
        await(4, n);
        @(posedge i_clk);
        check(done, 0);
        check(last_len >= `TPBS_MC_CLKS * mc - 3 && last_len <= `TPBS_MC_CLKS * mc, 1);
        check(last_wr, w);
    endtask
    // ====
    // Main sequence
    initial begin
        int s, t, sel, n;
        void'($urandom(32'h95ee15ea));
        repeat (12) @(posedge i_clk);
        i_resetn <= 1;
        repeat (3) @(posedge i_clk);
        bus(0, `TPBS_ADDR_CTRL, 0, 4'h1);
        check(rdat, 32'(m_ctrl));
        move(0, 0);
        bus(1, `TPBS_ADDR_CTRL, 32'h0000_0000, 4'h1);
        move(0, 1);
        bus(1, `TPBS_ADDR_CTRL, 32'h0000_003F, 4'h0);
        bus(0, `TPBS_ADDR_CTRL, 0, 4'h1);
        check(rdat, 32'(m_ctrl));
        bus(0, 4'h8, 0, 4'h1);
        check(rdat, 32'h00);
        for (s = 0; s < 8; s++) begin
            sel = $urandom_range(7);
            bus(1, `TPBS_ADDR_CTRL, 32'({2'($urandom_range(3)), 3'(sel), 3'(s)}), 4'h1);
            bus(0, `TPBS_ADDR_CTRL, 0, 4'h1);
            check(rdat, 32'(m_ctrl));
            move(0, s[0]);
            move(1, ~s[0]);
            for (t = 0; t < 3; t++) begin
                await(t, n);
                await(t, n);
                check(n, sel[t] ? `TPBS_DIV_FAST : `TPBS_DIV_SLOW);
            end
        end
        // Status while a stretched move runs, then idle again
        {req, intl, wr} <= 3'b100;
        @(posedge i_clk);
        req <= 0;
        bus(0, `TPBS_ADDR_STATUS, 0, 4'h1);
        check(rdat, 32'h2);
        await(4, n);
        @(posedge i_clk);
        bus(0, `TPBS_ADDR_STATUS, 0, 4'h1);
        check(rdat, 32'h0);
        // Mid-run reset brings the stretch field back
        i_resetn <= 0;
        repeat (2) @(posedge i_clk);
        check({ack, done, rds, wrs}, 0);
        i_resetn <= 1;
        m_ctrl = `TPBS_CTRL_RESET;
        repeat (3) @(posedge i_clk);
        bus(0, `TPBS_ADDR_CTRL, 0, 4'h1);
        check(rdat, 32'(m_ctrl));
        move(0, 0);
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        complete_run;
    end
endmodule
